//--- rtl/erx_pkg.sv
// Package for the exception recognition unit: map, fields, resets, types
//
// Behaviour
// RULE1: Instruction exceptions taken in program order
// RULE2: Earlier instructions and their exceptions go first
// RULE3: Several conditions: only the first is handled
// RULE4: Drain pipeline before external or decrementer
// RULE5: Reset and machine check never wait
// RULE6: Reset and machine check outrank everything
// RULE7: At most one precise exception reported
// RULE8: Async precise waits for instruction exceptions
// RULE9: Precise FP mode plus summary flag: program
// RULE10: FP precise only when a mode bit set
// RULE11: Resume address loaded on every entry
// RULE12: Resume address marks a completion boundary
// RULE13: Status save captures and restores state
// RULE14: Info in bits 0-15, state in 16-31
// RULE15: Enable bit clear holds off async precise
// RULE16: Privilege bit set allows user instructions only
// RULE17: Masked async conditions latched until enabled
// RULE18: Enable bit cleared on every exception taken
// RULE19: Order: reset, check, instruction, external, decrementer
// RULE20: State copied before entry changes it
package erx_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ERX_RESUME_OFS = 8'h00;
    localparam logic [7:0] ERX_STATUS_SAVE_OFS = 8'h04;
    localparam logic [7:0] ERX_MSW_OFS = 8'h08;
    localparam logic [7:0] ERX_UNIT_STAT_OFS = 8'h0C;

    // ----------------------------------------------------------------
    // Machine state word fields, bit n of the word is bit 31-n here;
    // only bits 16-31 are stored, bits 0-15 read as zero
    // ----------------------------------------------------------------
    localparam int ERX_INT_ENABLE_POS = 15;
    localparam int ERX_USER_PRIV_POS = 14;
    localparam int ERX_FP_MODE_LOW_POS = 11;
    localparam int ERX_FP_MODE_HIGH_POS = 8;
    localparam logic [15:0] ERX_MSW_RST = 16'h0000;
    localparam logic [31:0] ERX_WORD_RST = 32'h00000000;

    // ----------------------------------------------------------------
    // Exception causes, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ERX_C_NONE = 6'h00,
        ERX_C_RESET = 6'h20,
        ERX_C_MCHECK = 6'h10,
        ERX_C_INSTR = 6'h08,
        ERX_C_PROGRAM = 6'h04,
        ERX_C_EXTINT = 6'h02,
        ERX_C_DEC = 6'h01
    } erx_cause_t;

    typedef enum logic [1:0] {
        ERX_S_RUN = 2'h1,
        ERX_S_SYNC = 2'h2
    } erx_state_t;

    // In-order completion report from the pipelines
    typedef struct packed {
        logic valid;
        logic [31:0] pc;
        logic [31:0] next_pc;
        logic [7:0] cond;
        logic fp_op;
        logic priv_op;
    } erx_cmp_t;

    // Exception taken
    typedef struct packed {
        logic valid;
        erx_cause_t cause;
        logic [31:0] addr;
    } erx_exc_t;

endpackage

//--- rtl/erx_exception_unit.sv
// Exception recognition unit: ordering, entry save, enable gating, APB access
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module erx_exception_unit
    import erx_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pipelines
    input wire erx_cmp_t cmp,
    input wire logic pipe_drained,
    input wire logic [31:0] pipe_next_pc,
    input wire logic rfi_exec,
    input wire logic fp_enabled_summary_flag,
    output logic hold_dispatch,
    output logic user_only,
    output logic [31:0] rfi_target,
    output erx_exc_t exc,
    // Sources
    input wire logic ext_int_pin,
    input wire logic sreset_pin,
    input wire logic mcheck_pin,
    input wire logic dec_event
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Index of the first condition encountered (lowest bit)
    function automatic logic [3:0] first_set(input logic [7:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic apb_hit(input logic [31:0] a, input logic [7:0] ofs);
        return a == {24'h000000, ofs};
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sync1_q, sync2_q, sync3_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync3_q <= 3'h0;
        end else begin
            sync1_q <= {ext_int_pin, sreset_pin, mcheck_pin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    logic ext_lvl, sreset_evt, mcheck_evt;
    assign ext_lvl = sync2_q[2];
    assign sreset_evt = sync2_q[1] & ~sync3_q[1];
    assign mcheck_evt = sync2_q[0] & ~sync3_q[0];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    erx_state_t state_q, state_d;
    logic [31:0] resume_q, resume_d;
    logic [31:0] ssave_q, ssave_d;
    logic [15:0] msw_q, msw_d;
    logic ext_pend_q, ext_pend_d;
    logic dec_pend_q, dec_pend_d;
    erx_exc_t exc_q, exc_d;
    erx_cause_t last_q, last_d;
    logic [31:0] prdata_q, prdata_d;

    logic wr_acc, rd_setup, int_en, fp_mode, instr_exc, prog_exc;
    logic [3:0] cond_idx;
    logic [15:0] info;
    erx_cause_t take;
    logic [31:0] take_addr;

    assign wr_acc = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign int_en = msw_q[ERX_INT_ENABLE_POS];
    assign fp_mode = msw_q[ERX_FP_MODE_LOW_POS] | msw_q[ERX_FP_MODE_HIGH_POS]; //RULE10

    // Only completing instructions report, and completion is in order
    assign prog_exc = cmp.valid & ((cmp.fp_op & fp_mode & fp_enabled_summary_flag) //RULE9
        | (cmp.priv_op & msw_q[ERX_USER_PRIV_POS])); //RULE16
    assign instr_exc = cmp.valid & (|cmp.cond); //RULE1
    assign cond_idx = first_set(cmp.cond); //RULE3

    // ----------------------------------------------------------------
    // Recognition
    // ----------------------------------------------------------------
    always_comb begin
        take = ERX_C_NONE;
        take_addr = pipe_next_pc;
        state_d = state_q;
        if (sreset_evt) begin //RULE6
            take = ERX_C_RESET; //RULE5
            state_d = ERX_S_RUN;
        end else if (mcheck_evt) begin //RULE6
            take = ERX_C_MCHECK; //RULE5
            state_d = ERX_S_RUN;
        end else if (instr_exc) begin //RULE19
            take = ERX_C_INSTR; //RULE2
            take_addr = cmp.pc; //RULE12
            state_d = ERX_S_RUN;
        end else if (prog_exc) begin
            take = ERX_C_PROGRAM;
            take_addr = cmp.pc; //RULE12
            state_d = ERX_S_RUN;
        end else begin
            unique case (state_q)
                ERX_S_RUN: begin
                    if (int_en & (ext_pend_q | dec_pend_q)) begin //RULE15
                        state_d = ERX_S_SYNC; //RULE4
                    end
                end
                ERX_S_SYNC: begin
                    if (!int_en) begin //RULE15
                        state_d = ERX_S_RUN;
                    end else if (pipe_drained & ~cmp.valid) begin //RULE8
                        take = ext_pend_q ? ERX_C_EXTINT : ERX_C_DEC; //RULE19
                        state_d = ERX_S_RUN;
                    end
                end
                default: begin
                    state_d = ERX_S_RUN;
                end
            endcase
        end
    end

    assign info = {10'(take), 2'h0, take == ERX_C_INSTR ? cond_idx : 4'h0};

    // ----------------------------------------------------------------
    // Pending latches: a new request wins over the take that clears
    // ----------------------------------------------------------------
    always_comb begin
        ext_pend_d = ext_pend_q;
        dec_pend_d = dec_pend_q;
        if (take == ERX_C_EXTINT) begin
            ext_pend_d = 1'b0;
        end
        if (take == ERX_C_DEC) begin
            dec_pend_d = 1'b0;
        end
        if (ext_lvl) begin
            ext_pend_d = 1'b1; //RULE17
        end
        if (dec_event) begin
            dec_pend_d = 1'b1; //RULE17
        end
    end

    // ----------------------------------------------------------------
    // Architected registers; entry beats rfi beats software write
    // ----------------------------------------------------------------
    always_comb begin
        resume_d = resume_q;
        ssave_d = ssave_q;
        msw_d = msw_q;
        last_d = last_q;
        exc_d = '0;
        if (wr_acc && apb_hit(paddr, ERX_RESUME_OFS)) begin
            resume_d = pwdata;
        end
        if (wr_acc && apb_hit(paddr, ERX_STATUS_SAVE_OFS)) begin
            ssave_d = pwdata;
        end
        if (wr_acc && apb_hit(paddr, ERX_MSW_OFS)) begin
            msw_d = pwdata[15:0];
        end
        if (rfi_exec) begin
            msw_d = ssave_q[15:0]; //RULE13
        end
        if (take != ERX_C_NONE) begin
            resume_d = take_addr; //RULE11
            ssave_d = {info, msw_q}; //RULE14 RULE20
            msw_d[ERX_INT_ENABLE_POS] = 1'b0; //RULE18
            last_d = take;
            exc_d.valid = 1'b1; //RULE7
            exc_d.cause = take;
            exc_d.addr = take_addr;
        end
    end

    // ----------------------------------------------------------------
    // APB read data, captured in the setup cycle
    // ----------------------------------------------------------------
    always_comb begin
        prdata_d = prdata_q;
        if (rd_setup) begin
            if (apb_hit(paddr, ERX_RESUME_OFS)) begin
                prdata_d = resume_q;
            end else if (apb_hit(paddr, ERX_STATUS_SAVE_OFS)) begin
                prdata_d = ssave_q;
            end else if (apb_hit(paddr, ERX_MSW_OFS)) begin
                prdata_d = {16'h0000, msw_q};
            end else if (apb_hit(paddr, ERX_UNIT_STAT_OFS)) begin
                prdata_d = {16'h0000, 2'h0, last_q, 4'h0, state_q, dec_pend_q, ext_pend_q};
            end else begin
                prdata_d = ERX_WORD_RST;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ERX_S_RUN;
            resume_q <= ERX_WORD_RST;
            ssave_q <= ERX_WORD_RST;
            msw_q <= ERX_MSW_RST;
            ext_pend_q <= 1'b0;
            dec_pend_q <= 1'b0;
            exc_q <= '0;
            last_q <= ERX_C_NONE;
            prdata_q <= ERX_WORD_RST;
        end else begin
            state_q <= state_d;
            resume_q <= resume_d;
            ssave_q <= ssave_d;
            msw_q <= msw_d;
            ext_pend_q <= ext_pend_d;
            dec_pend_q <= dec_pend_d;
            exc_q <= exc_d;
            last_q <= last_d;
            prdata_q <= prdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign hold_dispatch = (state_q == ERX_S_SYNC); //RULE4
    assign user_only = msw_q[ERX_USER_PRIV_POS]; //RULE16
    assign rfi_target = resume_q;
    assign exc = exc_q;
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(apb_hit(paddr, ERX_RESUME_OFS)
        | apb_hit(paddr, ERX_STATUS_SAVE_OFS) | apb_hit(paddr, ERX_MSW_OFS)
        | apb_hit(paddr, ERX_UNIT_STAT_OFS));

endmodule

//--- testbench/erx_pipe_model.sv
// Pipeline model: in-order completion reports and drain handshake
`timescale 1ns/100ps
module erx_pipe_model
    import erx_pkg::*;
(
    input wire logic core_clk,
    input wire logic hold_dispatch,
    output erx_cmp_t cmp,
    output logic pipe_drained,
    output logic [31:0] pipe_next_pc
);
    int stall = 0;
    int cnt = 0;
    initial begin
        cmp = '0;
        pipe_drained = 1'b0;
        pipe_next_pc = 32'h00001000;
    end
    // Drains only after stall cycles of held dispatch
    always @(posedge core_clk) begin
        cnt <= hold_dispatch ? cnt + 1 : 0;
        pipe_drained <= hold_dispatch && (cnt >= stall);
    end
    task automatic issue(input logic [31:0] pc, input logic [7:0] cond, input logic fp, pv);
        cmp <= '{1'b1, pc, pc + 32'h4, cond, fp, pv};
        pipe_next_pc <= pc + 32'h4;
        @(posedge core_clk);
        cmp <= '0;
    endtask
endmodule

//--- testbench/erx_exception_unit_sva.sv
// Port checker for the exception recognition unit
`timescale 1ns/100ps
module erx_exception_unit_sva
    import erx_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire erx_cmp_t cmp,
    input wire logic pipe_drained,
    input wire logic hold_dispatch,
    input wire logic user_only,
    input wire logic [31:0] rfi_target,
    input wire erx_exc_t exc,
    input wire logic sreset_pin,
    input wire logic mcheck_pin
);
    logic [3:0] async_q;
    logic quiet;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            async_q <= 4'h0;
        end else begin
            async_q <= {async_q[2:0], sreset_pin | mcheck_pin};
        end
    end
    assign quiet = (async_q == 4'h0) && !sreset_pin && !mcheck_pin;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    one_cause_a: assert property (exc.valid |-> $onehot(exc.cause))
        else $error("cause not one-hot");
    instr_taken_a: assert property (quiet && cmp.valid && cmp.cond != 8'h00 |=>
        exc.valid && exc.cause == ERX_C_INSTR && exc.addr == $past(cmp.pc)) else $error("instr");
    priv_taken_a: assert property (quiet && cmp.valid && cmp.cond == 8'h00 && cmp.priv_op
        && user_only |=> exc.valid && exc.cause == ERX_C_PROGRAM) else $error("privilege");
    async_drain_a: assert property (exc.valid && exc.cause inside {ERX_C_EXTINT, ERX_C_DEC}
        |-> $past(hold_dispatch) && $past(pipe_drained) && !$past(cmp.valid)) else $error("drain");
    sync_end_a: assert property (exc.valid |-> !hold_dispatch)
        else $error("still holding");
    resume_reg_a: assert property (exc.valid |-> rfi_target == exc.addr)
        else $error("resume address");
    reset_taken_a: assert property ($rose(sreset_pin) |-> ##[1:5]
        (exc.valid && exc.cause == ERX_C_RESET)) else $error("reset not taken");
    mcheck_taken_a: assert property ($rose(mcheck_pin) && !sreset_pin |-> ##[1:5]
        (exc.valid && exc.cause == ERX_C_MCHECK)) else $error("mcheck not taken");
    apb_answer_a: assert property (psel && penable |-> pready
        && pslverr == !(paddr inside {32'h0, 32'h4, 32'h8, 32'hC}))
        else $error("apb answer");
endmodule
bind erx_exception_unit erx_exception_unit_sva u_sva (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .cmp(cmp), .pipe_drained(pipe_drained), .hold_dispatch(hold_dispatch),
    .user_only(user_only), .rfi_target(rfi_target), .exc(exc), .sreset_pin(sreset_pin),
    .mcheck_pin(mcheck_pin));

//--- testbench/erx_exception_unit_test.sv
// Self-checking bench for the exception recognition unit
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("Error %0t: got %0h expected %0h", $time, (a), (e)); end end
module erx_exception_unit_test import erx_pkg::*;;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, rfi_exec = 0;
    logic fp_enabled_summary_flag = 0, ext_int_pin = 0, sreset_pin = 0, mcheck_pin = 0;
    logic dec_event = 0, pready, pslverr, hold_dispatch, user_only, pipe_drained, err;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd, pc, pipe_next_pc, rfi_target;
    logic [37:0] expq[$];
    logic [37:0] e;
    erx_cmp_t cmp;
    erx_exc_t exc;
    int miscompares = 0, total_checks = 0, cycles = 0, seed = 32'hC38B718F;
    always #20 core_clk = ~core_clk;
    erx_exception_unit u_erx_exception_unit (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp(cmp), .pipe_drained(pipe_drained),
        .pipe_next_pc(pipe_next_pc), .rfi_exec(rfi_exec), .hold_dispatch(hold_dispatch),
        .fp_enabled_summary_flag(fp_enabled_summary_flag), .user_only(user_only),
        .rfi_target(rfi_target), .exc(exc), .ext_int_pin(ext_int_pin),
        .sreset_pin(sreset_pin), .mcheck_pin(mcheck_pin), .dec_event(dec_event));
    erx_pipe_model u_erx_pipe_model (.core_clk(core_clk), .hold_dispatch(hold_dispatch),
        .cmp(cmp), .pipe_drained(pipe_drained), .pipe_next_pc(pipe_next_pc));
    task automatic results();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(rd, x)
    endtask
    task automatic settle();
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < 40 && expq.size() != 0; i++) @(posedge core_clk);
        `CHK(expq.size(), 0)
    endtask
    // Every exception taken is compared with the expected queue
    always @(posedge core_clk) begin
        cycles++;
        if (exc.valid === 1'b1) begin
            e = (expq.size() != 0) ? expq.pop_front() : 38'h0;
            `CHK({exc.cause, exc.addr}, e)
        end
        if (cycles > 4000) begin
            miscompares++;
            results();
        end
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rdchk(32'h0, 32'h0);
        rdchk(32'h4, 32'h0);
        rdchk(32'h8, 32'h0);
        rdchk(32'h10, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, 32'h8, 32'h00008800);
        pc = $random(seed) & 32'hFFFFFFF0;
        expq.push_back({ERX_C_INSTR, pc});
        u_erx_pipe_model.issue(pc, 8'h0C, 1'b0, 1'b0);
        settle();
        rdchk(32'h4, 32'h02028800);
        rdchk(32'h8, 32'h00000800);
        rfi_exec <= 1'b1;
        @(posedge core_clk);
        rfi_exec <= 1'b0;
        rdchk(32'h8, 32'h00008800);
        fp_enabled_summary_flag <= 1'b1;
        expq.push_back({ERX_C_PROGRAM, pc + 32'h4});
        u_erx_pipe_model.issue(pc + 32'h4, 8'h00, 1'b1, 1'b0);
        settle();
        apb(1'b1, 32'h8, 32'h0);
        u_erx_pipe_model.issue(pc + 32'h8, 8'h00, 1'b1, 1'b0);
        settle();
        apb(1'b1, 32'h8, 32'h00004000);
        `CHK(user_only, 1'b1)
        expq.push_back({ERX_C_PROGRAM, pc + 32'hC});
        u_erx_pipe_model.issue(pc + 32'hC, 8'h00, 1'b0, 1'b1);
        settle();
        ext_int_pin <= 1'b1;
        dec_event <= 1'b1;
        @(posedge core_clk);
        dec_event <= 1'b0;
        repeat (4) @(posedge core_clk);
        ext_int_pin <= 1'b0;
        settle();
        for (int k = 0; k < 2; k++) begin
            u_erx_pipe_model.stall = $random(seed) & 7;
            expq.push_back({k ? ERX_C_DEC : ERX_C_EXTINT, pipe_next_pc});
            apb(1'b1, 32'h8, 32'h00008000);
            settle();
            rdchk(32'h8, 32'h0);
            `CHK(rfi_target, pipe_next_pc)
        end
        ext_int_pin <= 1'b1;
        u_erx_pipe_model.stall = 30;
        repeat (4) @(posedge core_clk);
        ext_int_pin <= 1'b0;
        expq.push_back({ERX_C_MCHECK, pipe_next_pc});
        apb(1'b1, 32'h8, 32'h00008000);
        #1;
        `CHK(hold_dispatch, 1'b1)
        @(posedge core_clk);
        mcheck_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        mcheck_pin <= 1'b0;
        settle();
        expq.push_back({ERX_C_RESET, pipe_next_pc});
        sreset_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        sreset_pin <= 1'b0;
        settle();
        rdchk(32'hC, 32'h00002005);
        results();
    end
endmodule
